/* core/tsc_pkg.sv */
// shared constants and carrier types of the tdm switch timing core
package tsc_pkg;

	// ====================================================================
	// frame geometry
	localparam int STREAMS      = 8;   // serial streams each way
	localparam int CHANNELS     = 32;  // timeslots per frame
	localparam int BITS         = 8;   // bits per channel byte
	localparam int SLOT_CYCLES  = 16;  // clock cycles per timeslot
	localparam int FRAME_CYCLES = SLOT_CYCLES * CHANNELS; // 512 per frame
	localparam int STREAM_W     = $clog2(STREAMS);
	localparam int CHAN_W       = $clog2(CHANNELS);
	localparam int CYC_W        = $clog2(SLOT_CYCLES);
	localparam int ADDR_W       = STREAM_W + CHAN_W;

	// ====================================================================
	// positions inside a timeslot
	localparam logic [3:0] FIRST_CYC    = 4'h0; // timeslot starts here
	localparam logic [3:0] LAST_CYC     = 4'hF; // last bit lands here
	localparam logic [3:0] CYC_STEP     = 4'h1;
	localparam logic [4:0] FIRST_SLOT   = 5'h00;
	localparam logic [4:0] SLOT_STEP    = 5'h01;
	localparam logic       SAMPLE_PHASE = 1'b1; // odd cycles take a bit
	localparam logic       WRITE_PHASE  = 1'b0; // cyc[1] low: memory write
	localparam logic       FETCH_PHASE  = 1'b0; // even cycles fetch
	localparam logic [1:0] WINDOW_PHASE = 2'h3; // host window, every 4th

	// ====================================================================
	// host access selection and field positions
	localparam logic [1:0] SEL_DATA = 2'h0; // data memory, read only
	localparam logic [1:0] SEL_CONN = 2'h1; // source-select bytes
	localparam logic [1:0] SEL_MODE = 2'h2; // per-channel mode bits
	localparam int         MODE_BIT = 2;    // channel_mode_bit position
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef logic [BITS-1:0] tsc_byte_t;

	// one host request as it is presented on the pins
	typedef struct packed {
		logic                wr;     // high: write, low: read
		logic [1:0]          sel;    // which memory
		logic [STREAM_W-1:0] stream; // stream part of address
		logic [CHAN_W-1:0]   chan;   // channel part of address
		tsc_byte_t           data;   // write data
	} tsc_host_req_t;

	localparam int HOST_REQ_W = $bits(tsc_host_req_t);

	// host access sequencer states, one-hot
	typedef enum logic [1:0] {
		HS_IDLE = 2'b01,
		HS_PEND = 2'b10
	} tsc_host_state_t;

endpackage

/* core/tsc_sync.sv */
// two flip-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstN,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// ====================================================================
	// parameter check
	if (W < 1)
	begin : g_bad_w
		$error("tsc_sync: width must be at least one");
	end

	typedef struct packed {
		logic [W-1:0] first;  // read only by the second stage
		logic [W-1:0] second; // safe to use
	} tsc_sync_state_t;

	tsc_sync_state_t st_ff;   // registered state
	tsc_sync_state_t nxt_st;  // next state

	// ====================================================================
	// next state
	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.first  = din;
		nxt_st.second = st_ff.first;
	end

	// state register
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign dout = st_ff.second;

endmodule
`default_nettype wire

/* core/tsc_buf2.sv */
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module tsc_buf2 #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rstN,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);

	// ====================================================================
	// parameter check
	if (W < 1)
	begin : g_bad_w
		$error("tsc_buf2: width must be at least one");
	end

	typedef struct packed {
		logic [1:0]        v; // entry valid, 0 is the head
		logic [1:0][W-1:0] d; // entry data
	} tsc_buf_state_t;

	tsc_buf_state_t st_ff;   // registered state
	tsc_buf_state_t nxt_st;  // next state
	logic           pop;     // head leaves this cycle
	logic           push;    // new word enters this cycle

	// ====================================================================
	// shift on pop, then place the new word in the first free entry
	always_comb
	begin
		nxt_st = st_ff;
		pop    = st_ff.v[0] && outReady;
		push   = inValid && !st_ff.v[1];
		if (pop)
		begin
			nxt_st.d[0] = st_ff.d[1];
			nxt_st.v[0] = st_ff.v[1];
			nxt_st.v[1] = 1'b0;
		end
		if (push)
		begin
			if (!nxt_st.v[0])
			begin
				nxt_st.d[0] = inData;
				nxt_st.v[0] = 1'b1;
			end
			else
			begin
				nxt_st.d[1] = inData;
				nxt_st.v[1] = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// full only when the second entry holds a word
	assign inReady  = !st_ff.v[1];
	assign outValid = st_ff.v[0];
	assign outData  = st_ff.d[0];

endmodule
`default_nettype wire

/* core/tsc_timing_core.sv */
// tdm switch timing core: slot timing, data memory, output queueing
`timescale 1ns/1ps
`default_nettype none
module tsc_timing_core
	import tsc_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                arst_n,
	input  wire logic                framePulse,
	input  wire logic [STREAMS-1:0]  serialIn,
	output logic      [STREAMS-1:0]  serialOut,
	input  wire logic                hostStrobe,
	input  wire tsc_host_req_t       hostReq,
	output logic                     hostAck,
	output logic                     rdValid,
	input  wire logic                rdReady,
	output tsc_byte_t                rdData
);

	// ====================================================================
	// reset release
	logic [1:0] rstPipe_ff; // release shifts in ones
	logic       rstN;       // synchronous copy of the reset

	// assertion is asynchronous, release waits two edges
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rstPipe_ff <= 2'h0;
		else
			rstPipe_ff <= {rstPipe_ff[0], 1'b1};
	end
	assign rstN = rstPipe_ff[1];

	// ====================================================================
	// pin synchronisers
	localparam int PIN_W = 1 + STREAMS + 1 + HOST_REQ_W;

	logic                fpSync;     // frame pulse
	logic [STREAMS-1:0]  sinSync;    // serial inputs
	logic                strobeSync; // host strobe
	tsc_host_req_t       reqSync;    // host request fields

	// request fields must be stable before the strobe rises, so they
	// have passed the same two flip-flops when the strobe edge is seen
	tsc_sync #(
		.W    (PIN_W)
	) u_pins (
		.clk  (sys_clk),
		.rstN (rstN),
		.din  ({framePulse, serialIn, hostStrobe, hostReq}),
		.dout ({fpSync, sinSync, strobeSync, reqSync})
	);

	// ====================================================================
	// memories: data, source-select and mode bits per output channel
	localparam int MEM_DEPTH = STREAMS * CHANNELS;

	tsc_byte_t dataMem [MEM_DEPTH]; // input bytes, by stream and channel
	tsc_byte_t connMem [MEM_DEPTH]; // source-select or message bytes
	logic      modeMem [MEM_DEPTH]; // high: message mode

	// ====================================================================
	// module state
	typedef struct packed {
		logic [CYC_W-1:0]             cyc;       // cycle within slot
		logic [CHAN_W-1:0]            slot;      // current timeslot
		logic                         fpPrev;    // frame pulse edge
		logic                         strbPrev;  // strobe edge
		tsc_host_state_t              hs;        // host sequencer
		tsc_host_req_t                req;       // pending request
		logic                         ack;       // request completed
		logic [STREAMS-1:0][BITS-1:0] inShift;   // bits being received
		logic [STREAMS-1:0][BITS-1:0] hold;      // finished bytes
		logic [CHAN_W-1:0]            holdSlot;  // their channel
		logic [STREAMS-1:0][BITS-1:0] queue;     // bytes for next slot
		logic [STREAMS-1:0][BITS-1:0] outShift;  // bits being sent
	} tsc_core_state_t;

	tsc_core_state_t st_ff;      // registered state
	tsc_core_state_t nxt_st;     // next state

	logic              dmWe;      // stream path writes data memory
	logic [ADDR_W-1:0] dmAddr;    // write address
	tsc_byte_t         dmData;    // write data
	logic [STREAM_W-1:0] wrStream; // stream whose byte is written
	logic              cmWe;      // host writes a source-select byte
	logic              modeWe;    // host writes a mode bit
	logic [ADDR_W-1:0] hostAddr;  // pending request address
	logic              push;      // read answer enters the buffer
	tsc_byte_t         pushData;  // read answer
	logic              bufReady;  // buffer has room
	logic              fetchEn;   // an output byte is fetched
	logic [STREAM_W-1:0] fetchStream; // which output stream
	logic [CHAN_W-1:0] nextChan;  // channel of the following slot
	logic [ADDR_W-1:0] fetchAddr; // connection memory address
	tsc_byte_t         srcSel;    // source-select byte fetched
	tsc_byte_t         fetchByte; // byte handed to the queue
	logic              window;    // host access window this cycle

	// ====================================================================
	// next state
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.ack  = 1'b0;
		dmWe        = 1'b0;
		cmWe        = 1'b0;
		modeWe      = 1'b0;
		push        = 1'b0;
		pushData    = ZERO_BYTE;
		window      = (st_ff.cyc[1:0] == WINDOW_PHASE);
		hostAddr    = {st_ff.req.stream, st_ff.req.chan};

		// slot and frame counters, realigned on the frame pulse
		nxt_st.fpPrev = fpSync;
		if (fpSync && !st_ff.fpPrev)
		begin
			nxt_st.cyc  = FIRST_CYC;
			nxt_st.slot = FIRST_SLOT;
		end
		else
		begin
			nxt_st.cyc = st_ff.cyc + CYC_STEP;
			if (st_ff.cyc == LAST_CYC)
				nxt_st.slot = st_ff.slot + SLOT_STEP;
		end

		// receive: one bit every second cycle, msb first
		if (st_ff.cyc[0] == SAMPLE_PHASE)
		begin
			for (int s = 0; s < STREAMS; s++)
				nxt_st.inShift[s] = {st_ff.inShift[s][BITS-2:0], sinSync[s]};
		end
		// a byte counts as received only with its last bit
		if (st_ff.cyc == LAST_CYC)
		begin
			for (int s = 0; s < STREAMS; s++)
				nxt_st.hold[s] = {st_ff.inShift[s][BITS-2:0], sinSync[s]};
			nxt_st.holdSlot = st_ff.slot;
		end

		// write the held bytes in the next slot; streams s and s+4 share
		// a group of four cycles, which sets the host read delays
		wrStream = {st_ff.cyc[0], st_ff.cyc[3:2]};
		dmAddr   = {wrStream, st_ff.holdSlot};
		dmData   = st_ff.hold[wrStream];
		if (st_ff.cyc[1] == WRITE_PHASE)
			dmWe = 1'b1;

		// fetch for the following slot, output stream n at cycle 2n;
		// a write in the same cycle is not yet visible, which is what
		// limits the short paths to the listed stream pairs
		fetchStream = st_ff.cyc[3:1];
		nextChan    = st_ff.slot + SLOT_STEP;
		fetchAddr   = {fetchStream, nextChan};
		srcSel      = connMem[fetchAddr];
		fetchEn     = (st_ff.cyc[0] == FETCH_PHASE);
		if (modeMem[fetchAddr])
			fetchByte = srcSel;
		else
			fetchByte = dataMem[srcSel];
		if (fetchEn)
			nxt_st.queue[fetchStream] = fetchByte;

		// transmit: queued bytes start together at the slot boundary
		if (st_ff.cyc == LAST_CYC)
			nxt_st.outShift = st_ff.queue;
		else if (st_ff.cyc[0] == SAMPLE_PHASE)
		begin
			for (int s = 0; s < STREAMS; s++)
				nxt_st.outShift[s] = {st_ff.outShift[s][BITS-2:0], 1'b0};
		end

		// host sequencer: take on strobe rise, serve at the next window
		nxt_st.strbPrev = strobeSync;
		unique case (st_ff.hs)
			HS_IDLE:
			begin
				if (strobeSync && !st_ff.strbPrev)
				begin
					nxt_st.req = reqSync;
					nxt_st.hs  = HS_PEND;
				end
			end
			HS_PEND:
			begin
				// a read waits while the answer buffer is full
				if (window && (st_ff.req.wr || bufReady))
				begin
					nxt_st.hs  = HS_IDLE;
					nxt_st.ack = 1'b1;
					if (st_ff.req.wr)
					begin
						// a byte already queued keeps the old value
						cmWe   = (st_ff.req.sel == SEL_CONN);
						modeWe = (st_ff.req.sel == SEL_MODE);
					end
					else
					begin
						push = 1'b1;
						if (st_ff.req.sel == SEL_CONN)
							pushData = connMem[hostAddr];
						else if (st_ff.req.sel == SEL_MODE)
							pushData = {5'h00, modeMem[hostAddr], 2'h0};
						else
							pushData = dataMem[hostAddr];
					end
				end
			end
			default:
				nxt_st.hs = HS_IDLE;
		endcase
	end

	// ====================================================================
	// state register
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			st_ff    <= '0;
			st_ff.hs <= HS_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	// memory writes; contents are undefined until written
	always_ff @(posedge sys_clk)
	begin
		if (dmWe)
			dataMem[dmAddr] <= dmData;
		if (cmWe)
			connMem[hostAddr] <= st_ff.req.data;
		if (modeWe)
			modeMem[hostAddr] <= st_ff.req.data[MODE_BIT];
	end

	// ====================================================================
	// read answers wait here so a slow reader loses none
	tsc_buf2 #(
		.W        (BITS)
	) u_rdbuf (
		.clk      (sys_clk),
		.rstN     (rstN),
		.inValid  (push),
		.inReady  (bufReady),
		.inData   (pushData),
		.outValid (rdValid),
		.outReady (rdReady),
		.outData  (rdData)
	);

	// outputs straight from flip-flops
	always_comb
	begin
		for (int s = 0; s < STREAMS; s++)
			serialOut[s] = st_ff.outShift[s][BITS-1];
	end
	assign hostAck = st_ff.ack;

	// ====================================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstN);

	slot_length_a: assert property (
		st_ff.cyc == LAST_CYC && !(fpSync && !st_ff.fpPrev)
		|=> st_ff.cyc == FIRST_CYC && st_ff.slot == $past(st_ff.slot) + 5'h01)
		else $error("slot did not end after sixteen cycles");

	frame_wrap_a: assert property (
		st_ff.slot == 5'h1F && st_ff.cyc == LAST_CYC
		&& !(fpSync && !st_ff.fpPrev) |=> st_ff.slot == FIRST_SLOT)
		else $error("frame did not wrap after 32 slots");

	hold_load_a: assert property (
		st_ff.cyc == LAST_CYC ##1 st_ff.cyc == FIRST_CYC
		|-> st_ff.holdSlot == $past(st_ff.slot))
		else $error("held byte tagged with wrong channel");

	dm_write_time_a: assert property (
		dmWe && st_ff.slot != FIRST_SLOT
		|-> dmAddr[CHAN_W-1:0] == st_ff.slot - SLOT_STEP)
		else $error("data memory written outside following slot");

	fetch_order_a: assert property (
		fetchEn && st_ff.cyc != FIRST_CYC
		|-> fetchStream == $past(fetchStream, 2) + 3'h1)
		else $error("output fetch out of stream order");

	fetch_chan_a: assert property (
		fetchEn && st_ff.slot == 5'h1F |-> fetchAddr[CHAN_W-1:0] == 5'h00)
		else $error("fetch not for the following channel");

	load_out_a: assert property (
		st_ff.cyc == LAST_CYC |=> serialOut[0] == $past(st_ff.queue[0][7]))
		else $error("queued byte not sent at slot start");

	host_window_a: assert property (
		st_ff.hs == HS_PEND ##1 st_ff.hs == HS_IDLE
		|-> $past(st_ff.cyc[1:0]) == WINDOW_PHASE && st_ff.ack)
		else $error("host access served outside window");

	read_answer_a: assert property (
		push |=> rdValid)
		else $error("read answer lost");

endmodule
`default_nettype wire

/* bench/tsc_stream_model.sv */
// far-side model: frame pulse, serial input streams, output capture
`timescale 1ns/1ps
`default_nettype none
module tsc_stream_model
	import tsc_pkg::*;
(
	input  wire logic                                  clk,
	input  wire logic                                  go,
	input  wire logic [STREAMS-1:0][CHANNELS-1:0][7:0] txFrame,
	input  wire logic [STREAMS-1:0]                    serialOut,
	output var logic                                   framePulse,
	output var logic  [STREAMS-1:0]                    serialIn,
	output var int                                     cycNow,
	output var logic                                   rxDone,
	output var int                                     rxAt,
	output var logic  [STREAMS-1:0][7:0]               rxByte
);
	// ====================================================================
	// frame timing and input streams
	logic [STREAMS-1:0][7:0] shift; // capture shifter per stream
	int                      pos;   // frame position shown on the pins
	initial
	begin
		cycNow = 0;
		framePulse = 1'h0;
		serialIn = '0;
		rxDone = 1'h0;
		rxAt = 0;
		rxByte = '0;
		shift = '0;
	end
	// pins move 1 ns after the edge, the frame counter on it
	always @(posedge clk)
	begin
		if (go)
			cycNow <= cycNow + 1;
		#1;
		// pulse leads by sync flops plus a register, so cycle 0 is ours
		framePulse = go && (cycNow % FRAME_CYCLES == FRAME_CYCLES - 3);
		// bits lead by two cycles to cover the input synchroniser
		pos = (cycNow + 2) % FRAME_CYCLES;
		for (int s = 0; s < STREAMS; s++)
			serialIn[s] = txFrame[s][pos / 16][7 - (pos % 16) / 2];
	end
	// ====================================================================
	// output capture: each bit read late in its second cycle
	always @(negedge clk)
	begin
		rxDone <= 1'h0;
		if (cycNow % 2 == 1)
			for (int o = 0; o < STREAMS; o++)
				shift[o] = {shift[o][6:0], serialOut[o]};
		if (cycNow % SLOT_CYCLES == SLOT_CYCLES - 1)
		begin
			rxByte <= shift;
			rxAt <= cycNow;
			rxDone <= 1'h1;
		end
	end
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench: random traffic through the switch timing core
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		numChecks++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp); \
		end \
	end
module tb
	import tsc_pkg::*;
;
	// ====================================================================
	// signals and reference model
	logic                  sys_clk;
	logic                  arst_n;
	logic                  framePulse;
	logic [STREAMS-1:0]    serialIn;
	logic [STREAMS-1:0]    serialOut;
	logic                  hostStrobe;
	tsc_host_req_t         hostReq;
	logic                  hostAck;
	logic                  rdValid;
	logic                  rdReady;
	tsc_byte_t             rdData;
	logic                  go;        // starts the far-side frame timing
	logic                  stall;     // holds read answers back
	logic                  rxDone;
	logic [STREAMS-1:0][7:0] rxByte;
	int                    rxAt;
	int                    cycNow;
	int                    failures;
	int                    numChecks;
	int                    ackCnt;    // host requests served
	int                    ackSeen;
	int                    checkFrom; // no output checks during set-up
	int                    idx;
	logic [31:0]           rng;
	tsc_byte_t             cb;
	tsc_byte_t             rc;
	logic                  md;
	tsc_byte_t             rdExp;
	tsc_byte_t             rdGot;     // read answer taken at the edge
	logic                  rdTake;    // read handshake done at the edge
	tsc_byte_t             expQ [$];  // read answers still owed
	// four frames of input bytes, slot picked by frame number
	logic [STREAMS-1:0][CHANNELS-1:0][7:0] inHist [4];
	logic [STREAMS-1:0][CHANNELS-1:0][7:0] txFrame;
	// source and mode bytes with previous value and time of change
	tsc_byte_t             connNew [256];
	tsc_byte_t             connOld [256];
	logic                  modeNew [256];
	logic                  modeOld [256];
	int                    connT [256];
	int                    modeT [256];
	assign txFrame = inHist[((cycNow + 2) / FRAME_CYCLES) % 4];
	tsc_timing_core i_tsc_timing_core (
		.sys_clk    (sys_clk),
		.arst_n     (arst_n),
		.framePulse (framePulse),
		.serialIn   (serialIn),
		.serialOut  (serialOut),
		.hostStrobe (hostStrobe),
		.hostReq    (hostReq),
		.hostAck    (hostAck),
		.rdValid    (rdValid),
		.rdReady    (rdReady),
		.rdData     (rdData)
	);
	tsc_stream_model i_tsc_stream_model (
		.clk        (sys_clk),
		.go         (go),
		.txFrame    (txFrame),
		.serialOut  (serialOut),
		.framePulse (framePulse),
		.serialIn   (serialIn),
		.cycNow     (cycNow),
		.rxDone     (rxDone),
		.rxAt       (rxAt),
		.rxByte     (rxByte)
	);
	// ====================================================================
	// expectation functions
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	// newest byte of input s/c stored in memory before cycle t
	function automatic tsc_byte_t inAt(int s, int c, int t);
		int off;
		off = (c + 1) * SLOT_CYCLES + 4 * (s % 4) + s / 4;
		return inHist[((t - off - 1) / FRAME_CYCLES) % 4][s][c];
	endfunction
	// byte queued for output o channel c of frame f
	function automatic tsc_byte_t expOut(int o, int c, int f);
		int         t;
		logic       m;
		tsc_byte_t  b;
		t = f * FRAME_CYCLES + (c - 1) * SLOT_CYCLES + 2 * o;
		b = (connT[o * 32 + c] < t) ? connNew[o * 32 + c] : connOld[o * 32 + c];
		m = (modeT[o * 32 + c] < t) ? modeNew[o * 32 + c] : modeOld[o * 32 + c];
		if (m)
			return b;
		return inAt(int'(b[7:5]), int'(b[4:0]), t);
	endfunction
	task automatic fill(int k);
		for (int s = 0; s < STREAMS; s++)
			for (int c = 0; c < CHANNELS; c++)
				inHist[k % 4][s][c] = 8'(rnd());
	endtask
	// one host access; model updated at the serving window
	task automatic hostOp(logic wr, logic [1:0] sel, int i, tsc_byte_t d);
		int tw;
		tw = -1;
		@(posedge sys_clk);
		#1;
		// fields settle a cycle ahead of the strobe rise
		hostReq = '{wr, sel, i[7:5], i[4:0], d};
		@(posedge sys_clk);
		#1;
		hostStrobe = 1'h1;
		for (int k = 0; k < 300 && tw < 0; k++)
		begin
			@(posedge sys_clk);
			if (hostAck === 1'h1)
				tw = cycNow - 1;
		end
		`CHK(tw % 4, 3)
		if (wr && sel == SEL_CONN)
		begin
			connOld[i] = connNew[i];
			connNew[i] = d;
			connT[i] = tw;
		end
		if (wr && sel == SEL_MODE)
		begin
			modeOld[i] = modeNew[i];
			modeNew[i] = d[MODE_BIT];
			modeT[i] = tw;
		end
		if (!wr)
			expQ.push_back(sel == SEL_CONN ? connNew[i] : sel == SEL_MODE ?
				{5'h00, modeNew[i], 2'h0} : inAt(i / 32, i % 32, tw));
		#1;
		hostStrobe = 1'h0;
		// low long enough for the strobe synchroniser to see it
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ====================================================================
	// clock, stimulus helpers and monitors
	initial
	begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		if (go && cycNow % FRAME_CYCLES == 100)
			fill(cycNow / FRAME_CYCLES + 1);
		if (hostAck === 1'h1)
			ackCnt++;
		rdTake = (rdValid === 1'h1 && rdReady === 1'h1);
		rdGot  = rdData;
		if (rxDone && rxAt > checkFrom)
			for (int o = 0; o < STREAMS; o++)
				`CHK(rxByte[o], expOut(o, rxAt % 512 / 16, rxAt / 512))
		// the host task queues the owed answer at this same edge
		#1;
		if (rdTake)
		begin
			rdExp = expQ.pop_front();
			`CHK(rdGot, rdExp)
		end
		rdReady = !stall && (rnd() % 4 != 0);
	end
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		final_report();
	end
	// ====================================================================
	// main sequence
	initial
	begin
		rng = 32'h0001813E;
		arst_n = 1'h0;
		go = 1'h0;
		stall = 1'h0;
		hostStrobe = 1'h0;
		hostReq = '0;
		rdReady = 1'h0;
		failures = 0;
		numChecks = 0;
		ackCnt = 0;
		checkFrom = 1 << 30;
		fill(0);
		repeat (4) @(posedge sys_clk);
		#1 arst_n = 1'h1;
		repeat (4) @(posedge sys_clk);
		#1 go = 1'h1;
		repeat (600) @(posedge sys_clk);
		// every output channel gets a source; a few fixed routes test
		// wrap, a two-slot pair, a missed pair, same slot, three ahead
		for (int i = 0; i < 256; i++)
		begin
			rc = 8'(rnd());
			cb = rc;
			md = (rnd() % 4 == 0);
			case (i[7:0])
				8'h00: cb = 8'h1F;
				8'hE5: cb = 8'h63;
				8'h25: cb = 8'h23;
				8'h89: cb = 8'h89;
				8'h4C: cb = 8'hA9;
				default: ;
			endcase
			md = md && (cb == rc);
			hostOp(1'h1, SEL_CONN, i, cb);
			hostOp(1'h1, SEL_MODE, i, {5'h00, md, 2'h0});
		end
		checkFrom = cycNow + 64;
		repeat (1600) @(posedge sys_clk);
		// random host traffic at random phase against the slot timing
		for (int k = 0; k < 600; k++)
		begin
			idx = (k * 37) % 256;
			repeat (rnd() % 24) @(posedge sys_clk);
			case (rnd() % 8)
				0, 1: hostOp(1'h1, SEL_CONN, idx, 8'(rnd()));
				2: hostOp(1'h1, SEL_MODE, idx, 8'(rnd()));
				3: hostOp(1'h1, SEL_DATA, idx, 8'(rnd()));
				4, 5: hostOp(1'h0, SEL_DATA, idx, 8'h00);
				6: hostOp(1'h0, SEL_CONN, idx, 8'h00);
				default: hostOp(1'h0, SEL_MODE, idx, 8'h00);
			endcase
		end
		// reader stalls: two answers fill the buffer, the third waits
		stall = 1'h1;
		hostOp(1'h0, SEL_DATA, 3, 8'h00);
		hostOp(1'h0, SEL_CONN, 229, 8'h00);
		ackSeen = ackCnt;
		fork
			hostOp(1'h0, SEL_MODE, 229, 8'h00);
			begin
				repeat (60) @(posedge sys_clk);
				`CHK(ackCnt, ackSeen)
				stall = 1'h0;
			end
		join
		repeat (100) @(posedge sys_clk);
		`CHK(expQ.size(), 0)
		final_report();
	end
endmodule
`default_nettype wire
